// File: ddr2_pin_pkg.sv
package ddr2_pin_pkg;
	// ----------------------------------------
	// Command codes {select_n, ras_n, cas_n, we_n}
	// ----------------------------------------
	localparam logic [3:0] CMD_MODE_SET = 4'h0;
	localparam logic [3:0] CMD_ACTIVATE = 4'h3;
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_READ = 4'h5;
	// ----------------------------------------
	// Extended mode register 1 selection and fields
	// ----------------------------------------
	localparam logic [2:0] BANK_EMR1 = 3'h1;
	localparam int EMR1_DIFF_OFF_BIT = 10;
	localparam int EMR1_READ_STROBE_BIT = 11;
	localparam logic EMR1_DIFF_OFF_RESET = 1'b0;
	localparam logic EMR1_READ_STROBE_RESET = 1'b0;
	// ----------------------------------------
	// Widths and burst
	// ----------------------------------------
	localparam int ADDR_W = 14;
	localparam int BANK_W = 3;
	localparam int DATA_W = 8;
	localparam int BURST_LEN = 4;
	localparam int BEATS_PER_CLOCK = 2;
	localparam int CLOCK_PERIOD_NS = 50;
	typedef enum {ST_IDLE, ST_WRITE, ST_READ} burst_state_t;
endpackage

// File: ddr2_strobe_drv.sv
`timescale 1ns/100ps
module ddr2_strobe_drv (
	// Clock and reset
	input wire logic clock,
	input wire logic rstN,
	// Control
	input wire logic burstActive,
	input wire logic enable,
	input wire logic diffEnable,
	// Strobe pins
	output logic trueOut,
	output logic trueOeN,
	output logic compOut,
	output logic compOeN
);
	// ----------------------------------------
	// Strobe toggles once per beat pair, edge-aligned with the data
	// ----------------------------------------
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			trueOut <= 1'b0;
			compOut <= 1'b1;
		end else if (burstActive && enable) begin
			trueOut <= ~trueOut;
			compOut <= trueOut;
		end else begin
			trueOut <= 1'b0;
			compOut <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			trueOeN <= 1'b1;
			compOeN <= 1'b1;
		end else begin
			trueOeN <= ~(burstActive && enable);
			compOeN <= ~(burstActive && enable && diffEnable);
		end
	end
endmodule

// File: ddr2_cmd_mask_strobe_pins.sv
`timescale 1ns/100ps
// What this block does
// - Commands are ignored on any edge where chip select is sampled high.
// - Chip select is one bit of the command code with RAS, CAS, WE.
// - Write beats with the data mask sampled high are discarded.
// - The mask is taken per beat, on both strobe edges.
// - Extended register 1 bit A11 set makes the shared ball a read strobe.
// - While the read strobe is on, the write mask is ignored.
// - Complementary read strobe only with read strobe and differential mode.
// - Extended register 1 bit A10 set disables both complementary strobes.
// - Address and control are captured on the rising clock crossing.
// - Read data leaves as two beats per clock period.
// - Clock enable registered high runs, registered low stops internal clocking.
// - Complementary data strobe needs A10 of extended register 1 at zero.
module ddr2_cmd_mask_strobe_pins
	import ddr2_pin_pkg::*;
#(
	parameter int COL_W = 7
) (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Command pins
	input wire logic cke,
	input wire logic selectN,
	input wire logic rasN,
	input wire logic casN,
	input wire logic weN,
	input wire logic [ddr2_pin_pkg::BANK_W-1:0] bank,
	input wire logic [ddr2_pin_pkg::ADDR_W-1:0] addr,
	// Data pins, one beat per clock half
	input wire logic [ddr2_pin_pkg::DATA_W-1:0] dqInRise,
	input wire logic [ddr2_pin_pkg::DATA_W-1:0] dqInFall,
	output logic [ddr2_pin_pkg::DATA_W-1:0] dqOutRise,
	output logic [ddr2_pin_pkg::DATA_W-1:0] dqOutFall,
	output logic dqOeN,
	// Mask / read strobe ball
	input wire logic maskRise,
	input wire logic maskFall,
	output logic readStrobe,
	output logic readStrobeOeN,
	output logic readStrobeN,
	output logic readStrobeNOeN,
	// Data strobe
	output logic dataStrobe,
	output logic dataStrobeOeN,
	output logic dataStrobeN,
	output logic dataStrobeNOeN,
	// Status
	output logic clockActive
);
	import ddr2_pin_pkg::*;

	localparam int DEPTH = (1 << (BANK_W + COL_W));
	localparam int PAIRS = BURST_LEN / BEATS_PER_CLOCK;

	// Refused at elaboration: the burst wraps on two column bits and A10 is not a column bit
	if (COL_W < 2 || COL_W > 10) begin
		$error("COL_W out of range");
	end

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rstMeta_q;
	logic rstN;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rstMeta_q <= 1'b0;
			rstN <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstN <= rstMeta_q;
		end
	end

	// ----------------------------------------
	// Clock enable and command capture
	// ----------------------------------------
	logic cmdValid_q;
	logic [3:0] cmd_q;
	logic [BANK_W-1:0] bank_q;
	logic [ADDR_W-1:0] addr_q;

	// Internal clocking follows the enable sampled at each rising crossing
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			clockActive <= 1'b0;
		end else begin
			clockActive <= cke;
		end
	end

	// Everything is sampled on the rising crossing only
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			cmdValid_q <= 1'b0;
			cmd_q <= CMD_ACTIVATE;
			bank_q <= '0;
			addr_q <= '0;
		end else begin
			cmdValid_q <= cke && !selectN;
			cmd_q <= {selectN, rasN, casN, weN};
			bank_q <= bank;
			addr_q <= addr;
		end
	end

	// ----------------------------------------
	// Extended mode register 1 fields
	// ----------------------------------------
	logic readStrobeOn_q;
	logic diffOff_q;

	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			readStrobeOn_q <= EMR1_READ_STROBE_RESET;
			diffOff_q <= EMR1_DIFF_OFF_RESET;
		end else if (cmdValid_q && cmd_q == CMD_MODE_SET && bank_q == BANK_EMR1) begin
			readStrobeOn_q <= addr_q[EMR1_READ_STROBE_BIT];
			diffOff_q <= addr_q[EMR1_DIFF_OFF_BIT];
		end
	end

	// ----------------------------------------
	// Burst sequencing
	// ----------------------------------------
	burst_state_t state_q;
	logic [1:0] pair_q;
	logic [BANK_W+COL_W-1:0] base_q;

	// A stopped clock freezes the burst where it stands
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			state_q <= ST_IDLE;
			pair_q <= '0;
			base_q <= '0;
		end else if (cke) begin
			case (state_q)
				ST_IDLE: begin
					pair_q <= '0;
					base_q <= {bank_q, addr_q[COL_W-1:0]};
					if (cmdValid_q && cmd_q == CMD_WRITE) begin
						state_q <= ST_WRITE;
					end else if (cmdValid_q && cmd_q == CMD_READ) begin
						state_q <= ST_READ;
					end
				end
				ST_WRITE, ST_READ: begin
					if (pair_q == 2'(PAIRS - 1)) begin
						state_q <= ST_IDLE;
						pair_q <= '0;
					end else begin
						pair_q <= pair_q + 2'd1;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Column order runs up from the aligned burst base; the low two column bits of the command are dropped
	logic [BANK_W+COL_W-1:0] addrRise;
	logic [BANK_W+COL_W-1:0] addrFall;

	always_comb begin
		addrRise = {base_q[BANK_W+COL_W-1:2], pair_q[0], 1'b0};
		addrFall = {base_q[BANK_W+COL_W-1:2], pair_q[0], 1'b1};
	end

	// ----------------------------------------
	// Array with per-beat masking
	// ----------------------------------------
	logic [DATA_W-1:0] mem [DEPTH];
	logic writeBeats;
	logic keepRise;
	logic keepFall;

	// With the read strobe on, the shared ball carries no mask
	always_comb begin
		writeBeats = cke && state_q == ST_WRITE;
		keepRise = readStrobeOn_q || !maskRise;
		keepFall = readStrobeOn_q || !maskFall;
	end

	// Masked beats are simply not stored, so the old byte survives
	always_ff @(posedge clock) begin
		if (writeBeats && keepRise) begin
			mem[addrRise] <= dqInRise;
		end
		if (writeBeats && keepFall) begin
			mem[addrFall] <= dqInFall;
		end
	end

	// ----------------------------------------
	// Read data, two beats per clock
	// ----------------------------------------
	logic readBeats;

	always_comb begin
		readBeats = cke && state_q == ST_READ;
	end

	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			dqOutRise <= '0;
			dqOutFall <= '0;
			dqOeN <= 1'b1;
		end else begin
			dqOeN <= ~readBeats;
			if (readBeats) begin
				dqOutRise <= mem[addrRise];
				dqOutFall <= mem[addrFall];
			end
		end
	end

	// ----------------------------------------
	// Strobe drivers
	// ----------------------------------------
	ddr2_strobe_drv dataStrobeDrv (
		.clock(clock),
		.rstN(rstN),
		.burstActive(readBeats),
		.enable(1'b1),
		.diffEnable(!diffOff_q),
		.trueOut(dataStrobe),
		.trueOeN(dataStrobeOeN),
		.compOut(dataStrobeN),
		.compOeN(dataStrobeNOeN)
	);

	ddr2_strobe_drv readStrobeDrv (
		.clock(clock),
		.rstN(rstN),
		.burstActive(readBeats),
		.enable(readStrobeOn_q),
		.diffEnable(!diffOff_q),
		.trueOut(readStrobe),
		.trueOeN(readStrobeOeN),
		.compOut(readStrobeN),
		.compOeN(readStrobeNOeN)
	);
endmodule

// File: ddr2_pins_chk_sva.sv
`timescale 1ns/100ps
module ddr2_pins_chk
	import ddr2_pin_pkg::*;
(
	input wire logic clock, resetn, cke, selectN, rasN, casN, weN,
	input wire logic [BANK_W-1:0] bank,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic dqOeN, readStrobeOeN, readStrobeNOeN, dataStrobeNOeN, clockActive
);
	logic [1:0] emr_q;
	logic [1:0] resetDone_q;
	wire logic [3:0] cmd = {selectN, rasN, casN, weN};
	wire logic rdCmd = cke && cmd == CMD_READ;
	// Shadow of the strobe fields; it leads the device by an edge, harmless while pins idle
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			emr_q <= 2'h0;
		end else if (cke && cmd == CMD_MODE_SET && bank == BANK_EMR1) begin
			emr_q <= addr[EMR1_READ_STROBE_BIT-:2];
		end
	end
	// The device leaves reset two edges after the pin, so the checks wait as long
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			resetDone_q <= 2'h0;
		end else begin
			resetDone_q <= {resetDone_q[0], 1'b1};
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!resetDone_q[1]);
	sequence burst;
		!dqOeN [*2] ##1 dqOeN;
	endsequence
	read_burst_a: assert property (rdCmd |-> ##3 burst) else $error("burst");
	read_cause_a: assert property ($fell(dqOeN) |-> $past(rdCmd, 3)) else $error("cause");
	rdqs_on_a: assert property (emr_q[1] && !dqOeN |-> !readStrobeOeN) else $error("rdqs");
	rdqs_off_a: assert property (!emr_q[1] |-> readStrobeOeN) else $error("mask");
	rdqs_comp_a: assert property (!readStrobeNOeN |-> emr_q == 2'h2) else $error("rdqsn");
	diff_off_a: assert property (emr_q[0] |-> dataStrobeNOeN) else $error("diff");
	diff_on_a: assert property (!emr_q[0] && !dqOeN |-> !dataStrobeNOeN) else $error("dqsn");
	clock_run_a: assert property (cke [*2] |=> clockActive) else $error("cke");
	clock_stop_a: assert property (!cke |=> !clockActive) else $error("cke stop");
endmodule
bind ddr2_cmd_mask_strobe_pins ddr2_pins_chk chk (.*);

// File: ddr2_ctl_model.sv
`timescale 1ns/100ps
module ddr2_ctl_model
	import ddr2_pin_pkg::*;
(
	input wire logic clock,
	output logic cke, selectN, rasN, casN, weN, maskRise, maskFall,
	output logic [BANK_W-1:0] bank,
	output logic [ADDR_W-1:0] addr,
	output logic [DATA_W-1:0] dqInRise, dqInFall
);
	initial begin
		{cke, selectN, rasN, casN, weN, bank, addr, dqInRise, dqInFall, maskRise, maskFall} = '1;
	end
	// One selected cycle, then deselect; address inverted so no stale value passes
	task automatic cmd(input logic [3:0] c, input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a);
		@(posedge clock);
		{selectN, rasN, casN, weN, bank, addr} <= {c, b, a};
		@(posedge clock);
		{selectN, rasN, casN, weN, addr} <= {4'hf, ~a};
	endtask
	// Two clocks of beats, each beat with its own mask bit
	// The device takes the first beats one clock after it decodes the write
	task automatic beats(input logic [31:0] d, input logic [3:0] m);
		@(posedge clock);
		{dqInFall, dqInRise, maskFall, maskRise} <= {d[15:0], m[1:0]};
		@(posedge clock);
		{dqInFall, dqInRise, maskFall, maskRise} <= {d[31:16], m[3:2]};
		@(posedge clock);
		{dqInFall, dqInRise} <= ~d[31:16];
	endtask
	// Clock enable, changed on an edge like every other pin
	task automatic setCke(input logic e);
		cke <= e;
	endtask
endmodule

// File: ddr2_cmd_mask_strobe_pins_tb_top.sv
`timescale 1ns/100ps
module ddr2_cmd_mask_strobe_pins_tb_top;
	import ddr2_pin_pkg::*;
	logic clock, resetn, cke, selectN, rasN, casN, weN, maskRise, maskFall, dqOeN, readStrobe, readStrobeOeN;
	logic readStrobeN, readStrobeNOeN, dataStrobe, dataStrobeOeN, dataStrobeN, dataStrobeNOeN, clockActive;
	logic [BANK_W-1:0] bank;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] dqInRise, dqInFall, dqOutRise, dqOutFall;
	logic [1:0] emr;
	logic [31:0] got, mem[int];
	int num_errors, checks, cycles, seed;
	wire logic [3:0] oe = {dqOeN, readStrobeOeN, readStrobeNOeN, dataStrobeNOeN};
	ddr2_ctl_model ctl (.*);
	ddr2_cmd_mask_strobe_pins DUT (.*);
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic complete_run();
		$display("%0d checks %0d errors", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Reference keeps unmasked bytes of selected writes, and every byte while the read strobe is on
	task automatic wr(input logic [3:0] c, input int a, input logic [31:0] d, input logic [3:0] m);
		ctl.cmd(c, 3'h0, a[ADDR_W-1:0]);
		ctl.beats(d, m);
		for (int i = 0; i < 4; i++) begin
			if (c == CMD_WRITE && cke && (emr[1] || !m[i])) begin
				mem[a][8*i+:8] = d[8*i+:8];
			end
		end
	endtask
	task automatic rd(input int a);
		ctl.cmd(CMD_READ, 3'h0, a[ADDR_W-1:0]);
		repeat (2) @(posedge clock);
		#1;
		got[15:0] = {dqOutFall, dqOutRise};
		chk("oe", oe, {1'b0, !emr[1], emr != 2'h2, emr[0]});
		chk("strobe0", {27'h0, dataStrobe, dataStrobeN, readStrobe, readStrobeN, dataStrobeOeN}, {27'h0, 2'b10, emr[1], !emr[1], 1'b0});
		@(posedge clock);
		#1;
		got[31:16] = {dqOutFall, dqOutRise};
		chk("strobe1", {27'h0, dataStrobe, dataStrobeN, readStrobe, readStrobeN, dataStrobeOeN}, 32'h0a);
		chk("data", got, mem[a]);
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles > 1000) begin
			num_errors++;
			complete_run();
		end
	end
	initial begin
		seed = 32'h067e;
		resetn = 1'b0;
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		repeat (3) @(posedge clock);
		for (int k = 0; k < 4; k++) begin
			emr = 2'(k);
			ctl.cmd(CMD_MODE_SET, BANK_EMR1, 14'(k) << EMR1_DIFF_OFF_BIT);
			wr(CMD_WRITE, 4 * k, $random(seed), 4'h0);
			wr(CMD_WRITE, 4 * k, $random(seed), 4'($random(seed)));
			wr(4'hc, 4 * k, $random(seed), 4'h0);
			rd(4 * k);
		end
		@(posedge clock);
		resetn <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		chk("reset", {27'h0, oe, clockActive}, 32'h1e);
		@(posedge clock);
		resetn <= 1'b1;
		emr = 2'h0;
		repeat (3) @(posedge clock);
		ctl.setCke(1'b0);
		wr(CMD_WRITE, 0, $random(seed), 4'h0);
		#1;
		chk("clk", {31'h0, clockActive}, 32'h0);
		@(posedge clock);
		ctl.setCke(1'b1);
		rd(0);
		complete_run();
	end
endmodule
